// ### hw/dcs_pkg.sv
// constants and types for the read-channel status and error flag block
// assumes one register clock and an AXI4-Lite register slave
package dcs_pkg;
	localparam int          ADDR_W      = 8;
	localparam logic [7:0]  OFF_CTRL    = 8'h00;
	localparam logic [7:0]  OFF_STAT    = 8'h04;
	localparam int          BIT_RUN     = 0;
	localparam int          BIT_HALTED  = 0;
	localparam int          BIT_SG      = 3;
	localparam int          BIT_DINT    = 4;
	localparam int          BIT_DSLV    = 5;
	localparam int          BIT_DDEC    = 6;
	localparam int          BIT_RSV7    = 7;
	localparam int          BIT_SINT    = 8;
	localparam int          BIT_SSLV    = 9;
	localparam int          BIT_SDEC    = 10;
	localparam int          BIT_RSV11   = 11;
	localparam int          BIT_CMPL    = 12;
	localparam int          BIT_DLY     = 13;
	localparam int          BIT_ERR     = 14;
	localparam int          THR_LSB     = 16;
	localparam int          THR_MSB     = 23;
	localparam logic [7:0]  THR_RESET   = 8'h01;
	localparam logic        RUN_RESET   = 1'b0;
	localparam logic [2:0]  EN_RESET    = 3'h0;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;
	// flag vectors are indexed [14:4] like the status word
	localparam logic [14:4] ERR_MASK    = 11'h077;
	localparam logic [14:4] SG_ONLY     = 11'h271;
	localparam logic [14:4] RSVD_MASK   = 11'h088;
	localparam logic [14:4] W1C_MASK    = 11'h700;
	typedef enum logic [1:0] {
		DCS_HALTED = 2'h0,
		DCS_RUN    = 2'h1,
		DCS_STOP   = 2'h3
	} dcs_halt_t;
endpackage

// ### hw/dcs_sticky.sv
// one sticky event flag: hardware sets, software clears, set wins
// assumes all inputs are on i_clk_sys
`timescale 1ns/10ps
module dcs_sticky
	import dcs_pkg::*;
(
	input  wire logic i_clk_sys,
	input  wire logic i_reset_n,
	input  wire logic i_set,
	input  wire logic i_clr,
	input  wire logic i_force_zero,
	output logic      o_flag
);
	typedef struct packed {
		logic flag;
	} dcs_sticky_t;

	dcs_sticky_t s;
	dcs_sticky_t next_s;

	always_comb begin
		next_s = s;
		if (i_clr)
			next_s.flag = 1'b0;
		if (i_set)
			next_s.flag = 1'b1;
		if (i_force_zero)
			next_s.flag = 1'b0;
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_reset_n)
			s <= '0;
		else
			s <= next_s;
	end

	assign o_flag = s.flag;

	property p_set_wins;
		@(posedge i_clk_sys) disable iff (!i_reset_n)
		(i_set && !i_force_zero) |=> o_flag;
	endproperty
	a_set_wins: assert property (p_set_wins)
		else $error("flag lost a set event");
endmodule // dcs_sticky

// ### hw/dcs_thresh.sv
// completion threshold counter: qualifies the completion interrupt
// assumes events and acks are single-cycle pulses on i_clk_sys
`timescale 1ns/10ps
module dcs_thresh
	import dcs_pkg::*;
(
	input  wire logic       i_clk_sys,
	input  wire logic       i_reset_n,
	input  wire logic [7:0] i_threshold,
	input  wire logic       i_event,
	input  wire logic       i_ack,
	output logic            o_met,
	output logic      [7:0] o_count
);
	typedef struct packed {
		logic       met;
		logic [7:0] count;
		logic [7:0] last;
	} dcs_thresh_t;

	dcs_thresh_t s;
	dcs_thresh_t next_s;
	logic [7:0]  thr;
	logic [7:0]  cur;

	// a threshold of zero behaves as one so the interrupt can never hang
	assign thr = (i_threshold == 8'h00) ? 8'h01 : i_threshold;
	// a new threshold restarts the countdown, else the count left over
	// from the old one would qualify the interrupt too early
	assign cur = (thr != s.last) ? thr : s.count;

	always_comb begin
		next_s       = s;
		next_s.last  = thr;
		next_s.count = cur;
		if (i_ack)
			next_s.met = 1'b0;
		if (i_event) begin
			if (cur <= 8'h01) begin
				next_s.met   = 1'b1;
				next_s.count = thr;
			end else begin
				next_s.count = cur - 8'h01;
			end
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_reset_n)
			s <= '{met: 1'b0, count: THR_RESET, last: THR_RESET};
		else
			s <= next_s;
	end

	assign o_met   = s.met;
	assign o_count = s.count;

	property p_reach;
		@(posedge i_clk_sys) disable iff (!i_reset_n)
		(i_event && cur == 8'h01) |=> o_met;
	endproperty
	a_reach: assert property (p_reach)
		else $error("threshold reached but not flagged");
endmodule // dcs_thresh

// ### hw/dcs_status.sv
// read-channel status, error and interrupt flags with AXI4-Lite access
// assumes error and completion inputs are one-cycle pulses from logic
// on i_clk_sys and i_engine_busy is a level from the same domain
//
// Functional notes
// - zero-length descriptor sets data internal error
// - any error clears run, halt after idle
// - buffer read slave error sets bit five
// - buffer decode error sets bit six
// - bits seven and eleven read zero
// - stale descriptor sets descriptor internal error
// - descriptor slave error sets bit nine
// - descriptor pointer decode error sets bit ten
// - simple mode zeroes descriptor-only flags
// - descriptor mode completion on end-of-frame
// - simple mode completion on transfer done
// - completion interrupt needs enable and threshold
// - delay timeout flag, interrupt when enabled
// - error flag, interrupt when enabled
// - interrupt flags stay until software clears
// - error flags read-only to software
// - bit zero shows halted state
//
// Implementation choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module dcs_status
	import dcs_pkg::*;
#(
	parameter bit DESC_ENGINE_PRESENT = 1'b1
) (
	input  wire logic              i_clk_sys,
	input  wire logic              i_reset_n,
	input  wire logic              i_s_axi_awvalid,
	output logic                   o_s_axi_awready,
	input  wire logic [ADDR_W-1:0] i_s_axi_awaddr,
	input  wire logic              i_s_axi_wvalid,
	output logic                   o_s_axi_wready,
	input  wire logic [31:0]       i_s_axi_wdata,
	input  wire logic [3:0]        i_s_axi_wstrb,
	output logic                   o_s_axi_bvalid,
	input  wire logic              i_s_axi_bready,
	output logic [1:0]             o_s_axi_bresp,
	input  wire logic              i_s_axi_arvalid,
	output logic                   o_s_axi_arready,
	input  wire logic [ADDR_W-1:0] i_s_axi_araddr,
	output logic                   o_s_axi_rvalid,
	input  wire logic              i_s_axi_rready,
	output logic [31:0]            o_s_axi_rdata,
	output logic [1:0]             o_s_axi_rresp,
	input  wire logic              i_desc_len_zero,
	input  wire logic              i_data_slave_error,
	input  wire logic              i_data_decode_error,
	input  wire logic              i_desc_stale,
	input  wire logic              i_desc_slave_error,
	input  wire logic              i_desc_decode_error,
	input  wire logic              i_desc_done_eof,
	input  wire logic              i_xfer_done,
	input  wire logic              i_delay_timeout,
	input  wire logic              i_engine_busy,
	output logic                   o_run_stop_control,
	output logic                   o_halted_flag,
	output logic                   o_irq
);
	typedef struct packed {
		logic              awready;
		logic              wready;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              aw_held;
		logic              w_held;
		logic [ADDR_W-1:0] awaddr;
		logic [31:0]       wdata;
		logic [3:0]        wstrb;
		logic              arready;
		logic              rvalid;
		logic [1:0]        rresp;
		logic [31:0]       rdata;
		logic              run_stop;
		logic [2:0]        irq_en;
		logic [7:0]        threshold;
		dcs_halt_t         halt;
		logic              halted;
		logic              irq;
	} dcs_state_t;

	dcs_state_t    s;
	dcs_state_t    next_s;
	logic [14:4]   set_raw;
	logic [14:4]   set_vec;
	logic [14:4]   clr_vec;
	logic [14:4]   zero_vec;
	logic [14:4]   flags;
	logic          any_err_evt;
	logic          any_err_flag;
	logic          cmpl_evt;
	logic          thr_met;
	logic [7:0]    thr_count;
	logic [7:0]    thr_used;
	logic          do_write;
	logic          wr_ctrl;
	logic          wr_stat;
	logic [31:0]   wmask;
	logic [31:0]   wbits;
	logic [31:0]   stat_word;
	logic [31:0]   ctrl_word;

	// completion source depends on the build mode
	assign cmpl_evt = DESC_ENGINE_PRESENT ? i_desc_done_eof
	                                      : i_xfer_done;

	always_comb begin
		set_raw           = '0;
		set_raw[BIT_DINT] = i_desc_len_zero;
		set_raw[BIT_DSLV] = i_data_slave_error;
		set_raw[BIT_DDEC] = i_data_decode_error;
		set_raw[BIT_SINT] = i_desc_stale;
		set_raw[BIT_SSLV] = i_desc_slave_error;
		set_raw[BIT_SDEC] = i_desc_decode_error;
		set_raw[BIT_CMPL] = cmpl_evt;
		set_raw[BIT_DLY]  = i_delay_timeout;
	end

	assign zero_vec    = DESC_ENGINE_PRESENT ? '0 : SG_ONLY;
	assign any_err_evt = |(set_raw & ERR_MASK & ~zero_vec);
	assign any_err_flag = |(flags & ERR_MASK);

	always_comb begin
		set_vec          = set_raw & ~RSVD_MASK & ~W1C_MASK;
		set_vec[BIT_CMPL] = cmpl_evt;
		set_vec[BIT_DLY]  = i_delay_timeout;
		set_vec[BIT_ERR]  = any_err_evt;
	end

	// write decode; the bus transfer itself is taken in the struct
	assign do_write = s.aw_held && s.w_held && !s.bvalid;
	assign wr_ctrl  = do_write && (s.awaddr[ADDR_W-1:2] == OFF_CTRL[7:2]);
	assign wr_stat  = do_write && (s.awaddr[ADDR_W-1:2] == OFF_STAT[7:2]);
	assign wmask    = {{8{s.wstrb[3]}}, {8{s.wstrb[2]}},
	                   {8{s.wstrb[1]}}, {8{s.wstrb[0]}}};
	assign wbits    = s.wdata & wmask;

	// only the three event flags take a write; error flags ignore it
	assign clr_vec = wr_stat ? (wbits[14:4] & W1C_MASK) : '0;

	genvar gi;
	generate
		for (gi = 4; gi <= 14; gi++) begin : g_flag
			if (RSVD_MASK[gi]) begin : g_rsvd
				assign flags[gi] = 1'b0;
			end else begin : g_bit
				dcs_sticky u_flag (
					.i_clk_sys    (i_clk_sys),
					.i_reset_n    (i_reset_n),
					.i_set        (set_vec[gi]),
					.i_clr        (clr_vec[gi]),
					.i_force_zero (zero_vec[gi]),
					.o_flag       (flags[gi])
				);
			end
		end
	endgenerate

	// simple mode has no threshold, every completion qualifies
	assign thr_used = DESC_ENGINE_PRESENT ? s.threshold : 8'h01;

	dcs_thresh u_thresh (
		.i_clk_sys   (i_clk_sys),
		.i_reset_n   (i_reset_n),
		.i_threshold (thr_used),
		.i_event     (cmpl_evt),
		.i_ack       (clr_vec[BIT_CMPL]),
		.o_met       (thr_met),
		.o_count     (thr_count)
	);

	always_comb begin
		stat_word                  = '0;
		stat_word[BIT_HALTED]      = s.halted;
		stat_word[BIT_SG]          = DESC_ENGINE_PRESENT;
		stat_word[14:4]            = flags & ~RSVD_MASK;
		if (DESC_ENGINE_PRESENT)
			stat_word[THR_MSB:THR_LSB] = thr_count;
	end

	always_comb begin
		ctrl_word                  = '0;
		ctrl_word[BIT_RUN]         = s.run_stop;
		ctrl_word[14:12]           = s.irq_en;
		ctrl_word[THR_MSB:THR_LSB] = s.threshold;
	end

	always_comb begin
		next_s = s;
		// write address and data are taken independently
		if (i_s_axi_awvalid && s.awready) begin
			next_s.aw_held = 1'b1;
			next_s.awaddr  = i_s_axi_awaddr;
		end
		if (i_s_axi_wvalid && s.wready) begin
			next_s.w_held = 1'b1;
			next_s.wdata  = i_s_axi_wdata;
			next_s.wstrb  = i_s_axi_wstrb;
		end
		if (s.bvalid && i_s_axi_bready)
			next_s.bvalid = 1'b0;
		if (do_write) begin
			next_s.aw_held = 1'b0;
			next_s.w_held  = 1'b0;
			next_s.bvalid  = 1'b1;
			next_s.bresp   = (wr_ctrl || wr_stat) ? RESP_OKAY
			                                      : RESP_SLVERR;
		end
		if (wr_ctrl) begin
			if (s.wstrb[0])
				next_s.run_stop = wbits[BIT_RUN] && !any_err_flag;
			if (s.wstrb[1])
				next_s.irq_en = wbits[14:12];
			if (s.wstrb[2])
				next_s.threshold = wbits[THR_MSB:THR_LSB];
		end
		// an error stops the channel at once, even over a write
		if (any_err_evt)
			next_s.run_stop = 1'b0;
		// read channel
		if (s.rvalid && i_s_axi_rready)
			next_s.rvalid = 1'b0;
		if (i_s_axi_arvalid && s.arready) begin
			next_s.rvalid = 1'b1;
			next_s.rresp  = RESP_OKAY;
			if (i_s_axi_araddr[ADDR_W-1:2] == OFF_STAT[7:2])
				next_s.rdata = stat_word;
			else if (i_s_axi_araddr[ADDR_W-1:2] == OFF_CTRL[7:2])
				next_s.rdata = ctrl_word;
			else begin
				next_s.rdata = '0;
				next_s.rresp = RESP_SLVERR;
			end
		end
		next_s.awready = !next_s.aw_held && !next_s.bvalid;
		next_s.wready  = !next_s.w_held && !next_s.bvalid;
		next_s.arready = !next_s.rvalid;
		// halt sequence: stop request, then wait for the engine to drain
		case (s.halt)
			DCS_HALTED: begin
				if (s.run_stop)
					next_s.halt = DCS_RUN;
			end
			DCS_RUN: begin
				if (!s.run_stop)
					next_s.halt = DCS_STOP;
			end
			DCS_STOP: begin
				if (!i_engine_busy)
					next_s.halt = DCS_HALTED;
			end
			default: next_s.halt = DCS_HALTED;
		endcase
		next_s.halted = (next_s.halt == DCS_HALTED);
		// registered from the flags, so the line trails them by a cycle
		next_s.irq = (flags[BIT_CMPL] && s.irq_en[0] && thr_met)
		          || (flags[BIT_DLY] && s.irq_en[1])
		          || (flags[BIT_ERR] && s.irq_en[2]);
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_reset_n) begin
			s           <= '0;
			s.awready   <= 1'b1;
			s.wready    <= 1'b1;
			s.arready   <= 1'b1;
			s.run_stop  <= RUN_RESET;
			s.irq_en    <= EN_RESET;
			s.threshold <= THR_RESET;
			s.halt      <= DCS_HALTED;
			s.halted    <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	assign o_s_axi_awready    = s.awready;
	assign o_s_axi_wready     = s.wready;
	assign o_s_axi_bvalid     = s.bvalid;
	assign o_s_axi_bresp      = s.bresp;
	assign o_s_axi_arready    = s.arready;
	assign o_s_axi_rvalid     = s.rvalid;
	assign o_s_axi_rdata      = s.rdata;
	assign o_s_axi_rresp      = s.rresp;
	assign o_run_stop_control = s.run_stop;
	assign o_halted_flag      = s.halted;
	assign o_irq              = s.irq;

	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_reset_n);

	property p_len_zero;
		i_desc_len_zero && DESC_ENGINE_PRESENT |=> flags[BIT_DINT];
	endproperty
	a_len_zero: assert property (p_len_zero)
		else $error("zero length did not set data internal error");

	sequence s_err_seen;
		any_err_evt;
	endsequence
	sequence s_stopped;
		!o_run_stop_control [*2];
	endsequence
	property p_err_stop;
		s_err_seen |=> s_stopped;
	endproperty
	a_err_stop: assert property (p_err_stop)
		else $error("run control not cleared after error");

	property p_dslv;
		i_data_slave_error |=> flags[BIT_DSLV];
	endproperty
	a_dslv: assert property (p_dslv)
		else $error("data slave error flag not set");

	property p_ddec;
		i_data_decode_error |=> flags[BIT_DDEC];
	endproperty
	a_ddec: assert property (p_ddec)
		else $error("data decode error flag not set");

	property p_rsvd;
		!stat_word[BIT_RSV7] && !stat_word[BIT_RSV11];
	endproperty
	a_rsvd: assert property (p_rsvd)
		else $error("reserved status bit reads one");

	property p_sg_errs;
		DESC_ENGINE_PRESENT && (i_desc_stale || i_desc_slave_error
		|| i_desc_decode_error) |=> |flags[BIT_SDEC:BIT_SINT];
	endproperty
	a_sg_errs: assert property (p_sg_errs)
		else $error("descriptor error flag not set");

	property p_simple;
		!DESC_ENGINE_PRESENT |-> !(|(flags & SG_ONLY));
	endproperty
	a_simple: assert property (p_simple)
		else $error("descriptor-only flag set in simple mode");

	property p_cmpl;
		cmpl_evt |=> flags[BIT_CMPL];
	endproperty
	a_cmpl: assert property (p_cmpl)
		else $error("completion flag not set");

	property p_irq_cause;
		o_irq |-> $past(flags[BIT_CMPL] && s.irq_en[0] && thr_met)
		       || $past(flags[BIT_DLY] && s.irq_en[1])
		       || $past(flags[BIT_ERR] && s.irq_en[2]);
	endproperty
	a_irq_cause: assert property (p_irq_cause)
		else $error("interrupt without enabled cause");

	property p_err_ro;
		!$fell(|(flags & ERR_MASK));
	endproperty
	a_err_ro: assert property (p_err_ro)
		else $error("error flag cleared while running");

	property p_halt_seq;
		(s.halt == DCS_STOP && !i_engine_busy) |=> o_halted_flag;
	endproperty
	a_halt_seq: assert property (p_halt_seq)
		else $error("halted not set after engine went idle");

	property p_err_irq;
		$rose(|(flags & ERR_MASK)) |-> flags[BIT_ERR];
	endproperty
	a_err_irq: assert property (p_err_irq)
		else $error("error interrupt flag lags error flag");
endmodule // dcs_status

// ### bench/dcs_far_model.sv
// far-side model: turns commanded bus outcomes into engine pulses
// assumes the bench raises i_fire for one cycle per outcome
`timescale 1ns/10ps
module dcs_far_model (
	input  wire logic       i_clk_sys,
	input  wire logic       i_reset_n,
	input  wire logic       i_fire,
	input  wire logic [3:0] i_kind,
	input  wire logic [3:0] i_stall,
	output logic      [8:0] o_events,
	output logic            o_engine_busy
);
	logic [3:0] left;

	// busy lingers so that a halt has to wait for the datapath to drain
	always_ff @(posedge i_clk_sys) begin
		if (!i_reset_n) begin
			o_events <= 9'h000;
			left     <= 4'h0;
		end else begin
			o_events <= i_fire ? 9'h001 << i_kind : 9'h000;
			if (i_fire)
				left <= i_stall;
			else if (left != 4'h0)
				left <= left - 4'h1;
		end
	end

	assign o_engine_busy = left != 4'h0;
endmodule // dcs_far_model

// ### bench/dcs_status_test.sv
// self-checking bench for the read-channel status block
// assumes dcs_pkg, the design and the far-side model are compiled first
`timescale 1ns/10ps
module dcs_status_test;
	import dcs_pkg::*;
	logic              i_clk_sys, i_reset_n, i_engine_busy;
	logic              i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready;
	logic              i_s_axi_arvalid, i_s_axi_rready;
	logic [ADDR_W-1:0] i_s_axi_awaddr, i_s_axi_araddr;
	logic [31:0]       i_s_axi_wdata, o_s_axi_rdata, s_rdata;
	logic [3:0]        i_s_axi_wstrb, kind, stall;
	logic              o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid;
	logic              o_s_axi_arready, o_s_axi_rvalid, fire;
	logic [1:0]        o_s_axi_bresp, o_s_axi_rresp, r;
	logic              o_run_stop_control, o_halted_flag, o_irq;
	logic              s_run, s_irq, err_d, err_s;
	logic              i_desc_len_zero, i_data_slave_error;
	logic              i_data_decode_error, i_desc_stale;
	logic              i_desc_slave_error, i_desc_decode_error;
	logic              i_desc_done_eof, i_xfer_done, i_delay_timeout;
	logic [8:0]        ev;
	logic [31:0]       d, sd;
	int                num_errors, n_checks;
	typedef struct packed {
		logic [3:0]  kind;
		logic [15:0] exp_d;
		logic [15:0] exp_s;
	} dcs_row_t;
	dcs_row_t          rows [9];

	assign {i_delay_timeout, i_xfer_done, i_desc_done_eof,
		i_desc_decode_error, i_desc_slave_error, i_desc_stale,
		i_data_decode_error, i_data_slave_error, i_desc_len_zero} = ev;

	dcs_status #(.DESC_ENGINE_PRESENT(1'b1)) dcs_status_i (.*);
	// simple-mode twin shares every input, so one bus cycle reads both
	dcs_status #(.DESC_ENGINE_PRESENT(1'b0)) dcs_status_s_i (
		.o_s_axi_awready(), .o_s_axi_wready(), .o_s_axi_bvalid(),
		.o_s_axi_arready(), .o_s_axi_rvalid(), .o_s_axi_bresp(),
		.o_s_axi_rdata(s_rdata), .o_s_axi_rresp(),
		.o_run_stop_control(s_run), .o_halted_flag(), .o_irq(s_irq), .*);
	dcs_far_model dcs_far_model_i (.i_clk_sys, .i_reset_n,
		.i_fire(fire), .i_kind(kind), .i_stall(stall), .o_events(ev),
		.o_engine_busy(i_engine_busy));

	initial begin
		i_clk_sys = 1'b0;
		forever #20 i_clk_sys = ~i_clk_sys;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic report_and_stop();
		if (num_errors == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v,
		input logic [1:0] er);
		logic aw, w;
		int   n;
		aw = 1'b1;
		w = 1'b1;
		n = 0;
		@(posedge i_clk_sys);
		i_s_axi_awvalid <= 1'b1;
		i_s_axi_awaddr  <= a;
		i_s_axi_wvalid  <= 1'b1;
		i_s_axi_wdata   <= v;
		i_s_axi_bready  <= 1'b1;
		forever begin
			@(posedge i_clk_sys);
			n++;
			aw = aw && !o_s_axi_awready;
			w = w && !o_s_axi_wready;
			i_s_axi_awvalid <= aw;
			i_s_axi_wvalid  <= w;
			if (o_s_axi_bvalid || n > 50)
				break;
		end
		if (!o_s_axi_bvalid)
			num_errors++;
		i_s_axi_bready <= 1'b0;
		chk({30'h0, o_s_axi_bresp}, {30'h0, er});
	endtask

	task automatic rd(input logic [7:0] a);
		int n;
		n = 0;
		@(posedge i_clk_sys);
		i_s_axi_arvalid <= 1'b1;
		i_s_axi_araddr  <= a;
		i_s_axi_rready  <= 1'b1;
		forever begin
			@(posedge i_clk_sys);
			n++;
			if (o_s_axi_arready)
				i_s_axi_arvalid <= 1'b0;
			if (o_s_axi_rvalid || n > 50)
				break;
		end
		if (!o_s_axi_rvalid)
			num_errors++;
		i_s_axi_rready <= 1'b0;
		d = o_s_axi_rdata;
		sd = s_rdata;
		r = o_s_axi_rresp;
	endtask

	task automatic pulse(input logic [3:0] k, input logic [3:0] s);
		@(posedge i_clk_sys);
		fire  <= 1'b1;
		kind  <= k;
		stall <= s;
		@(posedge i_clk_sys);
		fire <= 1'b0;
	endtask

	task automatic do_reset();
		@(posedge i_clk_sys);
		i_reset_n <= 1'b0;
		repeat (2) @(posedge i_clk_sys);
		i_reset_n <= 1'b1;
	endtask

	initial begin
		#200000;
		num_errors++;
		report_and_stop();
	end

	initial begin
		{i_reset_n, i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready} = 4'h0;
		{i_s_axi_arvalid, i_s_axi_rready, fire} = 3'h0;
		{i_s_axi_awaddr, i_s_axi_araddr, i_s_axi_wdata} = '0;
		i_s_axi_wstrb = 4'hf;
		{kind, stall} = 8'h00;
		rows = '{'{4'h0, 16'h4010, 16'h0000}, '{4'h1, 16'h4020, 16'h4020},
			'{4'h2, 16'h4040, 16'h4040}, '{4'h3, 16'h4100, 16'h0000},
			'{4'h4, 16'h4200, 16'h0000}, '{4'h5, 16'h4400, 16'h0000},
			'{4'h6, 16'h1000, 16'h0000}, '{4'h7, 16'h0000, 16'h1000},
			'{4'h8, 16'h2000, 16'h0000}};
		repeat (2) @(posedge i_clk_sys);
		i_reset_n <= 1'b1;
		rd(OFF_STAT);
		chk(d[15:0], 16'h0009);
		chk(sd[15:0], 16'h0001);
		foreach (rows[i]) begin
			do_reset();
			wr(OFF_CTRL, 32'h0001_7001, RESP_OKAY);
			rd(OFF_STAT);
			chk(d[0], 1'b0);
			pulse(rows[i].kind, 4'h6);
			repeat (3) @(posedge i_clk_sys);
			err_d = |rows[i].exp_d[10:4];
			err_s = |rows[i].exp_s[10:4];
			chk(o_run_stop_control, !err_d);
			chk(s_run, !err_s);
			chk(o_halted_flag, 1'b0);
			repeat (12) @(posedge i_clk_sys);
			chk(o_halted_flag, err_d);
			chk(o_irq, |rows[i].exp_d[14:12]);
			chk(s_irq, |rows[i].exp_s[14:12]);
			rd(OFF_STAT);
			chk(d[15:4], rows[i].exp_d[15:4]);
			chk(d[15:4], rows[i].exp_d[15:4]);
			chk(sd[15:4], rows[i].exp_s[15:4]);
		end
		do_reset();
		wr(OFF_CTRL, 32'h0000_0001, RESP_OKAY);
		pulse(4'h1, 4'h2);
		repeat (4) @(posedge i_clk_sys);
		chk(o_irq, 1'b0);
		wr(OFF_STAT, 32'h0000_0000, RESP_OKAY);
		rd(OFF_STAT);
		chk(d[15:4], 12'h402);
		wr(OFF_STAT, 32'hffff_ffff, RESP_OKAY);
		rd(OFF_STAT);
		chk(d[15:4], 12'h002);
		wr(OFF_CTRL, 32'h0000_0001, RESP_OKAY);
		chk(o_run_stop_control, 1'b0);
		do_reset();
		wr(OFF_CTRL, 32'h0000_0001, RESP_OKAY);
		pulse(4'h8, 4'h0);
		repeat (4) @(posedge i_clk_sys);
		chk(o_irq, 1'b0);
		wr(OFF_CTRL, 32'h0000_2001, RESP_OKAY);
		repeat (3) @(posedge i_clk_sys);
		chk(o_irq, 1'b1);
		wr(OFF_STAT, 32'h0000_2000, RESP_OKAY);
		repeat (3) @(posedge i_clk_sys);
		chk(o_irq, 1'b0);
		do_reset();
		wr(OFF_CTRL, 32'h0002_1001, RESP_OKAY);
		pulse(4'h6, 4'h0);
		repeat (4) @(posedge i_clk_sys);
		chk(o_irq, 1'b0);
		rd(OFF_STAT);
		chk(d[12], 1'b1);
		pulse(4'h6, 4'h0);
		repeat (4) @(posedge i_clk_sys);
		chk(o_irq, 1'b1);
		// unmapped offset must answer with an error and no data
		wr(8'h40, 32'hffff_ffff, RESP_SLVERR);
		rd(8'h40);
		chk({30'h0, r}, {30'h0, RESP_SLVERR});
		chk(d, 32'h0000_0000);
		report_and_stop();
	end
endmodule // dcs_status_test
